// *** rtl/uic_defines.svh ***
// Notes on behaviour
// RULE1: auto-wake bit set enables automatic resume signalling
// RULE2: keep-alive acts only in serial modes, clock only; code also applies it in uart mode
// RULE3: keep-alive honoured only when low-power-inactive is 1
// RULE4: keep-alive 0 unpowers clock, 1 keeps powered
// RULE5: uart select bit 2 switches pins to uart
// RULE6: device clears uart select on uart exit
// RULE7: bit 1 selects three-wire serial for fs/ls
// RULE8: bit 0 selects six-wire serial for fs/ls
// RULE9: device clears serial select on serial exit
// RULE10: set alias 0x08 reads control register contents
// RULE11: set alias ones set bits, zeros keep
// RULE12: bits reset 0; alias bit 0 read-only
// RULE13: clear alias 0x09 ones clear bits
// RULE14: link sets at most one interface select
// RULE15: set alias and direct writes share storage
`ifndef UIC_DEFINES_SVH
`define UIC_DEFINES_SVH
// ******************************
// register map
// ******************************
`define UIC_ADDR_CTRL      6'h07
`define UIC_ADDR_SET       6'h08
`define UIC_ADDR_CLR       6'h09
`define UIC_CTRL_RESET     8'h00
// ******************************
// field positions
// ******************************
`define UIC_BIT_SIX_WIRE   0
`define UIC_BIT_THREE_WIRE 1
`define UIC_BIT_UART       2
`define UIC_BIT_KEEPALIVE  3
`define UIC_BIT_AUTO_WAKE  4
// set alias may not touch bit 0
`define UIC_SET_MASK       8'hFE
`endif

// *** rtl/uic_pkg.sv ***
package uic_pkg;
    typedef enum logic [1:0] {
        UIC_IF_PARALLEL   = 2'b00,
        UIC_IF_UART       = 2'b01,
        UIC_IF_THREE_WIRE = 2'b10,
        UIC_IF_SIX_WIRE   = 2'b11
    } uic_if_mode_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rd_data;
    } uic_state_t;
endpackage

// *** rtl/uic_interface_control.sv ***
`timescale 1ns/1ps
`include "uic_defines.svh"
module uic_interface_control
    import uic_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // register access from the link
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // phy side
    input  wire logic       low_power_inactive,
    input  wire logic       uart_exit,
    input  wire logic       serial_exit,
    output uic_if_mode_t    if_mode,
    output logic            auto_wake_signalling,
    output logic            serial_clock_keepalive_n,
    output logic            internal_clock_power,
    output logic [7:0]      interface_control
);
    // ******************************
    // state
    // ******************************
    uic_state_t st_ff;
    uic_state_t nxt_st;
    logic       serial_mode;

    always_comb begin
        nxt_st = st_ff;
        if (reg_wr) begin
            case (reg_addr)
                `UIC_ADDR_CTRL: nxt_st.ctrl = reg_wdata;
                `UIC_ADDR_SET:  nxt_st.ctrl = st_ff.ctrl | (reg_wdata & `UIC_SET_MASK); // RULE11 RULE12 RULE15
                `UIC_ADDR_CLR:  nxt_st.ctrl = st_ff.ctrl & ~reg_wdata; // RULE13
                default:        nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
        // hardware exit wins over any write in the same cycle
        if (uart_exit) begin
            nxt_st.ctrl[`UIC_BIT_UART] = 1'b0; // RULE6
        end
        if (serial_exit) begin
            nxt_st.ctrl[`UIC_BIT_THREE_WIRE] = 1'b0; // RULE9
            nxt_st.ctrl[`UIC_BIT_SIX_WIRE]   = 1'b0; // RULE9
        end
        if (reg_rd) begin
            case (reg_addr)
                `UIC_ADDR_CTRL,
                `UIC_ADDR_SET,
                `UIC_ADDR_CLR: nxt_st.rd_data = st_ff.ctrl; // RULE10
                default:       nxt_st.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_ff <= '{ctrl: `UIC_CTRL_RESET, rd_data: 8'h00}; // RULE12
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ******************************
    // decoded outputs
    // ******************************
    always_comb begin
        // uart first, then three-wire, then six-wire if link breaks exclusivity
        if (st_ff.ctrl[`UIC_BIT_UART]) begin
            if_mode = UIC_IF_UART; // RULE5 RULE14
        end else if (st_ff.ctrl[`UIC_BIT_THREE_WIRE]) begin
            if_mode = UIC_IF_THREE_WIRE; // RULE7
        end else if (st_ff.ctrl[`UIC_BIT_SIX_WIRE]) begin
            if_mode = UIC_IF_SIX_WIRE; // RULE8
        end else begin
            if_mode = UIC_IF_PARALLEL;
        end
    end

    assign serial_mode              = (if_mode != UIC_IF_PARALLEL);
    assign auto_wake_signalling     = st_ff.ctrl[`UIC_BIT_AUTO_WAKE]; // RULE1
    assign serial_clock_keepalive_n = st_ff.ctrl[`UIC_BIT_KEEPALIVE];
    // clock gated only in serial/uart with low_power_inactive high
    assign internal_clock_power     = !(serial_mode && low_power_inactive) // RULE2 RULE3
                                      || st_ff.ctrl[`UIC_BIT_KEEPALIVE]; // RULE4
    assign interface_control        = st_ff.ctrl;
    assign reg_rdata                = st_ff.rd_data;

    // ******************************
    // assertions
    // ******************************
    property p_set_alias;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == `UIC_ADDR_SET && !uart_exit && !serial_exit)
        |=> ((st_ff.ctrl & ($past(reg_wdata) & `UIC_SET_MASK)) == ($past(reg_wdata) & `UIC_SET_MASK));
    endproperty
    a_set_alias: assert property (p_set_alias) else $error("set alias failed to set bits"); // RULE11

    property p_set_bit0;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == `UIC_ADDR_SET) |=> ($stable(st_ff.ctrl[0]) || !st_ff.ctrl[0]);
    endproperty
    a_set_bit0: assert property (p_set_bit0) else $error("set alias changed bit 0"); // RULE12

    property p_clr_alias;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == `UIC_ADDR_CLR) |=> ((st_ff.ctrl & $past(reg_wdata)) == 8'h00);
    endproperty
    a_clr_alias: assert property (p_clr_alias) else $error("clear alias left bits set"); // RULE13

    property p_uart_exit;
        @(posedge sys_clk) disable iff (!reset_n)
        uart_exit |=> !st_ff.ctrl[`UIC_BIT_UART];
    endproperty
    a_uart_exit: assert property (p_uart_exit) else $error("uart select not cleared"); // RULE6

    sequence s_serial_exit;
        serial_exit;
    endsequence
    property p_serial_exit;
        @(posedge sys_clk) disable iff (!reset_n)
        s_serial_exit |=> (st_ff.ctrl[1:0] == 2'b00) && (if_mode != UIC_IF_THREE_WIRE);
    endproperty
    a_serial_exit: assert property (p_serial_exit) else $error("serial select not cleared"); // RULE9

    property p_read_alias;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_rd && reg_addr == `UIC_ADDR_SET) |=> (reg_rdata == $past(st_ff.ctrl));
    endproperty
    a_read_alias: assert property (p_read_alias) else $error("alias read mismatch"); // RULE10

    property p_clock_ignore;
        @(posedge sys_clk) disable iff (!reset_n)
        !low_power_inactive |-> internal_clock_power;
    endproperty
    a_clock_ignore: assert property (p_clock_ignore) else $error("keepalive not ignored"); // RULE3

    property p_clock_off;
        @(posedge sys_clk) disable iff (!reset_n)
        (serial_mode && low_power_inactive && !serial_clock_keepalive_n) |-> !internal_clock_power;
    endproperty
    a_clock_off: assert property (p_clock_off) else $error("clock powered against keepalive"); // RULE4

    property p_uart_mode;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == `UIC_ADDR_CTRL && reg_wdata[`UIC_BIT_UART] && !uart_exit)
        |=> (if_mode == UIC_IF_UART);
    endproperty
    a_uart_mode: assert property (p_uart_mode) else $error("uart mode not entered"); // RULE5

    // ******************************
    // access sequences
    // ******************************
    sequence s_ctrl_write;
        reg_wr && (reg_addr == `UIC_ADDR_CTRL);
    endsequence

    sequence s_set_write;
        reg_wr && (reg_addr == `UIC_ADDR_SET);
    endsequence

    sequence s_clr_write;
        reg_wr && (reg_addr == `UIC_ADDR_CLR);
    endsequence

    sequence s_no_exit;
        !uart_exit && !serial_exit;
    endsequence

    sequence s_mapped_read;
        reg_rd && ((reg_addr == `UIC_ADDR_CTRL) || (reg_addr == `UIC_ADDR_SET)
                   || (reg_addr == `UIC_ADDR_CLR));
    endsequence

    // ******************************
    // register view checks
    // ******************************
    property p_wr_direct;
        @(posedge sys_clk) disable iff (!reset_n)
        s_ctrl_write ##0 s_no_exit |=> (st_ff.ctrl == $past(reg_wdata));
    endproperty
    a_wr_direct: assert property (p_wr_direct) else $error("write lost"); // RULE15

    property p_set_keep;
        @(posedge sys_clk) disable iff (!reset_n)
        s_set_write ##0 s_no_exit |=> ((st_ff.ctrl & $past(st_ff.ctrl)) == $past(st_ff.ctrl));
    endproperty
    a_set_keep: assert property (p_set_keep) else $error("set alias cleared a bit"); // RULE11

    property p_set_only;
        @(posedge sys_clk) disable iff (!reset_n)
        s_set_write |=> ((st_ff.ctrl & ~$past(st_ff.ctrl) & ~$past(reg_wdata)) == 8'h00);
    endproperty
    a_set_only: assert property (p_set_only) else $error("set alias set extra bit"); // RULE11

    property p_clr_keep;
        @(posedge sys_clk) disable iff (!reset_n)
        s_clr_write ##0 s_no_exit
        |=> ((st_ff.ctrl & ~$past(reg_wdata)) == ($past(st_ff.ctrl) & ~$past(reg_wdata)));
    endproperty
    a_clr_keep: assert property (p_clr_keep) else $error("clear alias lost a bit"); // RULE13

    property p_wake;
        @(posedge sys_clk) disable iff (!reset_n)
        s_ctrl_write ##0 s_no_exit
        |=> (auto_wake_signalling == $past(reg_wdata[`UIC_BIT_AUTO_WAKE]));
    endproperty
    a_wake: assert property (p_wake) else $error("auto wake not following"); // RULE1

    property p_three_mode;
        @(posedge sys_clk) disable iff (!reset_n)
        s_ctrl_write ##0 s_no_exit ##0 (reg_wdata[2:0] == 3'b010)
        |=> (if_mode == UIC_IF_THREE_WIRE);
    endproperty
    a_three_mode: assert property (p_three_mode) else $error("three-wire not set"); // RULE7

    property p_six_mode;
        @(posedge sys_clk) disable iff (!reset_n)
        s_ctrl_write ##0 s_no_exit ##0 (reg_wdata[2:0] == 3'b001)
        |=> (if_mode == UIC_IF_SIX_WIRE);
    endproperty
    a_six_mode: assert property (p_six_mode) else $error("six-wire not set"); // RULE8

    property p_par_mode;
        @(posedge sys_clk) disable iff (!reset_n)
        (st_ff.ctrl[2:0] == 3'b000) |-> (if_mode == UIC_IF_PARALLEL);
    endproperty
    a_par_mode: assert property (p_par_mode) else $error("parallel not set"); // RULE7 RULE8

    property p_keep_on;
        @(posedge sys_clk) disable iff (!reset_n)
        (serial_clock_keepalive_n && low_power_inactive) |-> internal_clock_power;
    endproperty
    a_keep_on: assert property (p_keep_on) else $error("clock off with keepalive"); // RULE4

    property p_par_clock;
        @(posedge sys_clk) disable iff (!reset_n)
        (if_mode == UIC_IF_PARALLEL) |-> internal_clock_power;
    endproperty
    a_par_clock: assert property (p_par_clock) else $error("clock off in parallel"); // RULE2

    property p_rd_mapped;
        @(posedge sys_clk) disable iff (!reset_n)
        s_mapped_read |=> (reg_rdata == $past(st_ff.ctrl));
    endproperty
    a_rd_mapped: assert property (p_rd_mapped) else $error("read view differs"); // RULE15

    property p_rd_unmapped;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_rd && (reg_addr != `UIC_ADDR_CTRL) && (reg_addr != `UIC_ADDR_SET)
         && (reg_addr != `UIC_ADDR_CLR)) |=> (reg_rdata == 8'h00);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_stands;
        @(posedge sys_clk) disable iff (!reset_n)
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rd_stands: assert property (p_rd_stands) else $error("read data moved");

    property p_ctrl_holds;
        @(posedge sys_clk) disable iff (!reset_n)
        (!reg_wr && !uart_exit && !serial_exit) |=> $stable(st_ff.ctrl);
    endproperty
    a_ctrl_holds: assert property (p_ctrl_holds) else $error("control changed idle"); // RULE15
endmodule // uic_interface_control

// *** testbench/uic_link_model.sv ***
`timescale 1ns/1ps
module uic_link_model (
    // register bus
    input  wire logic       sys_clk,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0,
    output logic      [5:0] reg_addr = 6'h00,
    output logic      [7:0] reg_wdata = 8'h00,
    input  wire logic [7:0] reg_rdata
);
    // callers set one select bit at a time, apart from the 0x05 set-alias write in t_uart
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
endmodule // uic_link_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
    import uic_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic lpi = 1'b1;
    logic uart_exit = 1'b0;
    logic serial_exit = 1'b0;
    logic wr, rd, aw, ka, pwr;
    logic [5:0] a;
    logic [7:0] wd, rdat, ctl, d;
    uic_if_mode_t md;
    int n_errors = 0;
    int compares = 0;
    always #10 sys_clk = ~sys_clk;
    uic_link_model uic_link_model_i (.sys_clk(sys_clk), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(a), .reg_wdata(wd), .reg_rdata(rdat));
    uic_interface_control uic_interface_control_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_wr(wr), .reg_rd(rd), .reg_addr(a), .reg_wdata(wd), .reg_rdata(rdat),
        .low_power_inactive(lpi), .uart_exit(uart_exit), .serial_exit(serial_exit),
        .if_mode(md), .auto_wake_signalling(aw), .serial_clock_keepalive_n(ka),
        .internal_clock_power(pwr), .interface_control(ctl));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic st(input logic [7:0] ec, input logic [1:0] em, input logic ep);
        @(negedge sys_clk);
        chk("ctrl", ec, ctl);
        chk("mode", {6'h00, em}, {6'h00, md});
        chk("clk_pwr", {7'h00, ep}, {7'h00, pwr});
    endtask
    task automatic final_report();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_uart();
        uic_link_model_i.rd(6'h07, d);
        chk("reset", 8'h00, d);
        chk("wake", 8'h00, {7'h00, aw});
        uic_link_model_i.wr(6'h08, 8'h05);
        st(8'h04, 2'h1, 1'b0);
        uic_link_model_i.rd(6'h08, d);
        chk("alias", 8'h04, d);
        @(posedge sys_clk) uart_exit <= 1'b1;
        @(posedge sys_clk) uart_exit <= 1'b0;
        st(8'h00, 2'h0, 1'b1);
        $display("uart test done");
    endtask
    task automatic t_serial();
        uic_link_model_i.wr(6'h07, 8'h02);
        st(8'h02, 2'h2, 1'b0);
        uic_link_model_i.wr(6'h08, 8'h08);
        st(8'h0A, 2'h2, 1'b1);
        chk("keep", 8'h01, {7'h00, ka});
        uic_link_model_i.wr(6'h09, 8'h08);
        st(8'h02, 2'h2, 1'b0);
        chk("keep", 8'h00, {7'h00, ka});
        @(posedge sys_clk) lpi <= 1'b0;
        st(8'h02, 2'h2, 1'b1);
        @(posedge sys_clk) lpi <= 1'b1;
        @(posedge sys_clk) serial_exit <= 1'b1;
        @(posedge sys_clk) serial_exit <= 1'b0;
        st(8'h00, 2'h0, 1'b1);
        $display("serial test done");
    endtask
    task automatic t_six();
        uic_link_model_i.wr(6'h07, 8'h11);
        st(8'h11, 2'h3, 1'b0);
        chk("wake", 8'h01, {7'h00, aw});
        uic_link_model_i.wr(6'h09, 8'h01);
        st(8'h10, 2'h0, 1'b1);
        uic_link_model_i.wr(6'h3F, 8'hFF);
        st(8'h10, 2'h0, 1'b1);
        uic_link_model_i.rd(6'h09, d);
        chk("clr_read", 8'h10, d);
        uic_link_model_i.rd(6'h3F, d);
        chk("unmapped", 8'h00, d);
        $display("six wire test done");
    endtask
    task automatic t_reset();
        @(posedge sys_clk) reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        st(8'h00, 2'h0, 1'b1);
        chk("wake", 8'h00, {7'h00, aw});
        uic_link_model_i.rd(6'h08, d);
        chk("alias", 8'h00, d);
        $display("reset test done");
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_uart();
        t_serial();
        t_six();
        t_reset();
        final_report();
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end
endmodule // tb
